// file: include/isac_pkg.sv
// Constants and types of the two-wire serial controller.
// Assumes a single 10 MHz clock and an 8-bit register port.
package isac_pkg;
  localparam int         AW         = 8;
  localparam int         CLK_NS     = 100;
  localparam int         BASE_HALF  = 8;
  // Register offsets in I/O space, data space adds OFS_DSPACE
  localparam logic [7:0] OFS_DIV    = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h01;
  localparam logic [7:0] OFS_OWN    = 8'h02;
  localparam logic [7:0] OFS_DATA   = 8'h03;
  localparam logic [7:0] OFS_CTL    = 8'h36;
  localparam logic [7:0] OFS_DSPACE = 8'h20;
  // Reset values
  localparam logic [7:0] RST_DIV    = 8'h00;
  localparam logic [7:0] RST_OWN    = 8'h7F;
  localparam logic [7:0] RST_DATA   = 8'hFF;
  // serial_control bit positions
  localparam int         CB_FLAG    = 7;
  localparam int         CB_ACK     = 6;
  localparam int         CB_STA     = 5;
  localparam int         CB_STO     = 4;
  localparam int         CB_WCOL    = 3;
  localparam int         CB_EN      = 2;
  localparam int         CB_IE      = 0;
  // Status codes, prescaler bits zero
  localparam logic [7:0] CODE_NONE  = 8'hF8;
  localparam logic [7:0] CODE_BERR  = 8'h00;
  localparam logic [7:0] CODE_STRT  = 8'h08;
  localparam logic [7:0] CODE_RSTRT = 8'h10;
  localparam logic [7:0] CODE_AWA   = 8'h18;
  localparam logic [7:0] CODE_AWN   = 8'h20;
  localparam logic [7:0] CODE_DTA   = 8'h28;
  localparam logic [7:0] CODE_DTN   = 8'h30;
  localparam logic [7:0] CODE_ARB   = 8'h38;
  localparam logic [7:0] CODE_ARA   = 8'h40;
  localparam logic [7:0] CODE_ARN   = 8'h48;
  localparam logic [7:0] CODE_DRA   = 8'h50;
  localparam logic [7:0] CODE_DRN   = 8'h58;
  localparam logic [7:0] CODE_SW    = 8'h60;
  localparam logic [7:0] CODE_SWL   = 8'h68;
  localparam logic [7:0] CODE_SDA   = 8'h80;
  localparam logic [7:0] CODE_SDN   = 8'h88;
  localparam logic [7:0] CODE_SRD   = 8'hA8;
  localparam logic [7:0] CODE_SRDL  = 8'hB0;
  localparam logic [7:0] CODE_STA   = 8'hB8;
  localparam logic [7:0] CODE_STN   = 8'hC0;

  typedef enum logic [2:0] {
    PH_IDLE, PH_START, PH_LOW, PH_HIGH, PH_STOP, PH_RS, PH_SLV, PH_HOLD
  } isac_ph_t;

  typedef struct packed {
    isac_ph_t    ph;
    logic [2:0]  scs;
    logic [2:0]  sds;
    logic        scl;
    logic        sda;
    logic        busy;
    logic [7:0]  div;
    logic [7:0]  own;
    logic [7:0]  sh;
    logic [7:0]  rd;
    logic [7:0]  stat;
    logic [1:0]  ps;
    logic        flag;
    logic        ack;
    logic        sta;
    logic        sto;
    logic        wcol;
    logic        en;
    logic        ie;
    logic        mst;
    logic        slv;
    logic        addr;
    logic        rw;
    logic        nack;
    logic        lost;
    logic [3:0]  bitn;
    logic [15:0] cnt;
    logic        sdrv;
    logic        cdrv;
    logic        irq;
    logic        zero;
  } isac_q_t;
endpackage

// file: rtl/isac_ctrl.sv
// Two-wire serial controller: registers, master/slave engine, arbitration.
// Assumes open-drain pins resolved outside; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Status code bits 7:3 read 0xF8 while the transfer-done flag is clear.
// - Illegal START or STOP inside a frame reports status 0x00.
// - A bus error sets the transfer-done flag.
// - Recovery enters not-addressed slave and clears stop request only.
// - Recovery releases both lines and sends no STOP.
// - After a repeated START the device stays bus master.
// - Identical bits from several masters cause no contention.
// - Sending one while the line reads zero loses arbitration.
// - After data loss: not-addressed slave or restart, as software selects.
// - After address loss: check own address, else act as data loss.
// - Eight-bit divider, reset zero, sets the master SCL rate.
// - Control bits: flag, ack, start, stop, collision, enable, -, irq.
// - Writing data while a byte shifts sets the collision flag.
// - SCL is held low while software prepares the next byte.
// - Registers answer at their offset and at offset plus 0x20.
// - Status register gives code in bits 7:3 with prescaler bits.
// - Two-bit prescaler selects 1, 4, 16 or 64.
module isac_ctrl (
  input  wire logic                   ref_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [isac_pkg::AW-1:0] reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire logic [7:0]             reg_wdata_i,
  output logic      [7:0]             reg_rdata_o,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe_o,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_o,
  output logic                        irq_o
);
  import isac_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o) || (a == o + OFS_DSPACE);
  endfunction

  function automatic logic [15:0] half_f(input logic [7:0] d, input logic [1:0] p);
    half_f = 16'(BASE_HALF) + (16'(d) << {p, 1'b0});
  endfunction

  isac_q_t     q;
  isac_q_t     n;
  logic        scl_nx;
  logic        sda_nx;
  logic        start_d;
  logic        stop_d;
  logic        bus_err;
  logic        mtx;
  logic        lose;
  logic [15:0] half;

  // Filtered level moves once the last two stages agree
  assign scl_nx  = (q.scs[1] == q.scs[2]) ? q.scs[2] : q.scl;
  assign sda_nx  = (q.sds[1] == q.sds[2]) ? q.sds[2] : q.sda;
  assign start_d = q.scl && scl_nx && q.sda && !sda_nx;
  assign stop_d  = q.scl && scl_nx && !q.sda && sda_nx;
  assign bus_err = (start_d || stop_d) && (q.bitn != 4'h0) &&
                   (q.ph == PH_LOW || q.ph == PH_HIGH || q.ph == PH_SLV);
  assign mtx     = q.addr || !q.rw;
  assign lose    = mtx && !q.sdrv && !q.sda && (q.bitn < 4'h8);
  assign half    = half_f(q.div, q.ps);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n      = q;
    n.scs  = {q.scs[1:0], scl_i};
    n.sds  = {q.sds[1:0], sda_i};
    n.scl  = scl_nx;
    n.sda  = sda_nx;
    if (start_d) begin
      n.busy = 1'b1;
    end else if (stop_d) begin
      n.busy = 1'b0;
    end
    if (q.cnt != 16'h0000) begin
      n.cnt = q.cnt - 16'h0001;
    end

    if (reg_wr_i) begin
      if (hit(reg_addr_i, OFS_DIV)) begin
        n.div = reg_wdata_i;
      end else if (hit(reg_addr_i, OFS_STAT)) begin
        n.ps = reg_wdata_i[1:0];
      end else if (hit(reg_addr_i, OFS_OWN)) begin
        n.own = reg_wdata_i;
      end else if (hit(reg_addr_i, OFS_DATA)) begin
        if (q.flag) begin
          n.sh   = reg_wdata_i;
          n.wcol = 1'b0;
        end else begin
          n.wcol = 1'b1;
        end
      end else if (hit(reg_addr_i, OFS_CTL)) begin
        n.ack = reg_wdata_i[CB_ACK];
        n.sta = reg_wdata_i[CB_STA];
        n.sto = reg_wdata_i[CB_STO];
        n.en  = reg_wdata_i[CB_EN];
        n.ie  = reg_wdata_i[CB_IE];
        if (reg_wdata_i[CB_FLAG]) begin
          n.flag = 1'b0;
        end
      end
    end

    if (hit(reg_addr_i, OFS_DIV)) begin
      n.rd = q.div;
    end else if (hit(reg_addr_i, OFS_STAT)) begin
      n.rd = {(q.flag ? q.stat[7:3] : CODE_NONE[7:3]), 1'b0, q.ps};
    end else if (hit(reg_addr_i, OFS_OWN)) begin
      n.rd = q.own;
    end else if (hit(reg_addr_i, OFS_DATA)) begin
      n.rd = q.sh;
    end else if (hit(reg_addr_i, OFS_CTL)) begin
      n.rd = {q.flag, q.ack, q.sta, q.sto, q.wcol, q.en, 1'b0, q.ie};
    end else begin
      n.rd = 8'h00;
    end

    // Engine runs after the register write so a hardware set wins
    if (!q.en) begin
      n.ph   = PH_IDLE;
      n.mst  = 1'b0;
      n.slv  = 1'b0;
      n.sdrv = 1'b0;
      n.cdrv = 1'b0;
    end else if (bus_err) begin
      n.stat = CODE_BERR;
      n.flag = 1'b1;
      n.ph   = PH_HOLD;
      n.mst  = 1'b0;
      n.slv  = 1'b0;
      n.sdrv = 1'b0;
      n.cdrv = 1'b0;
    end else begin
      case (q.ph)
        PH_IDLE: begin
          n.sdrv = 1'b0;
          n.cdrv = 1'b0;
          if (start_d) begin
            n.ph   = PH_SLV;
            n.bitn = 4'h0;
            n.addr = 1'b1;
            n.lost = 1'b0;
          end else if (q.sta && !q.busy && !q.flag) begin
            n.ph   = PH_START;
            n.sdrv = 1'b1;
            n.cnt  = half;
          end
        end
        PH_START: begin
          if (q.cnt == 16'h0000) begin
            n.cdrv = 1'b1;
            n.stat = q.mst ? CODE_RSTRT : CODE_STRT;
            n.mst  = 1'b1;
            n.addr = 1'b1;
            n.lost = 1'b0;
            n.flag = 1'b1;
            n.ph   = PH_HOLD;
          end
        end
        PH_HOLD: begin
          if (!q.scl) begin
            n.sdrv = 1'b0;
          end
          if (!q.flag) begin
            if (q.sto) begin
              n.sto = 1'b0;
              if (q.mst) begin
                n.ph   = PH_STOP;
                n.sdrv = 1'b1;
                n.cnt  = half;
              end else begin
                n.ph   = PH_IDLE;
                n.slv  = 1'b0;
                n.sdrv = 1'b0;
                n.cdrv = 1'b0;
              end
            end else if (q.sta && q.mst) begin
              n.ph   = PH_RS;
              n.sdrv = 1'b0;
              n.cnt  = half;
            end else if (q.mst) begin
              n.ph   = PH_LOW;
              n.bitn = 4'h0;
              n.cnt  = half;
            end else if (q.slv && !(q.rw && q.nack)) begin
              n.ph   = PH_SLV;
              n.bitn = 4'h0;
              n.cdrv = 1'b0;
              n.sdrv = q.rw && !q.sh[7];
            end else begin
              n.ph   = PH_IDLE;
              n.slv  = 1'b0;
              n.sdrv = 1'b0;
              n.cdrv = 1'b0;
            end
          end
        end
        PH_LOW: begin
          n.cdrv = 1'b1;
          if (!q.scl) begin
            n.sdrv = (q.bitn < 4'h8) ? (mtx && !q.sh[7]) : (!mtx && q.ack);
          end
          if (q.cnt == 16'h0000) begin
            n.cdrv = 1'b0;
            n.ph   = PH_HIGH;
            n.cnt  = half;
          end
        end
        PH_HIGH: begin
          if (!q.scl) begin
            n.cnt = half;
          end else if (q.cnt == 16'h0000) begin
            n.bitn = q.bitn + 4'h1;
            n.ph   = PH_LOW;
            n.cnt  = half;
            n.cdrv = 1'b1;
            if (q.bitn < 4'h8) begin
              n.sh = {q.sh[6:0], q.sda};
            end else begin
              n.nack = q.sda;
            end
            if (lose) begin
              n.mst  = 1'b0;
              n.sdrv = 1'b0;
              n.cdrv = 1'b0;
              n.lost = 1'b1;
              if (q.addr) begin
                n.ph = PH_SLV;
              end else begin
                n.ph   = PH_HOLD;
                n.stat = CODE_ARB;
                n.flag = 1'b1;
              end
            end else if (q.bitn == 4'h8) begin
              n.bitn = 4'h0;
              n.ph   = PH_HOLD;
              n.flag = 1'b1;
              n.addr = 1'b0;
              if (q.addr) begin
                n.rw   = q.sh[0];
                n.stat = q.sh[0] ? (q.sda ? CODE_ARN : CODE_ARA)
                                 : (q.sda ? CODE_AWN : CODE_AWA);
              end else if (mtx) begin
                n.stat = q.sda ? CODE_DTN : CODE_DTA;
              end else begin
                n.stat = q.ack ? CODE_DRA : CODE_DRN;
              end
            end
          end
        end
        PH_STOP, PH_RS: begin
          if (q.cdrv) begin
            if (q.cnt == 16'h0000) begin
              n.cdrv = 1'b0;
              n.cnt  = half;
            end
          end else if (!q.scl) begin
            n.cnt = half;
          end else if (q.cnt == 16'h0000) begin
            n.cnt = half;
            if (q.ph == PH_RS) begin
              n.ph   = PH_START;
              n.sdrv = 1'b1;
            end else begin
              n.ph   = PH_IDLE;
              n.sdrv = 1'b0;
              n.mst  = 1'b0;
            end
          end
        end
        PH_SLV: begin
          if (stop_d) begin
            n.ph  = PH_IDLE;
            n.slv = 1'b0;
          end else if (start_d) begin
            n.bitn = 4'h0;
            n.addr = 1'b1;
          end else if (scl_nx && !q.scl) begin
            if (q.bitn < 4'h8) begin
              n.sh = {q.sh[6:0], q.sda};
            end else begin
              n.nack = q.sda;
            end
            n.bitn = q.bitn + 4'h1;
          end else if (!scl_nx && q.scl) begin
            if (q.bitn == 4'h8) begin
              if (q.addr) begin
                if (q.sh[7:1] == q.own[7:1] && q.ack) begin
                  n.slv  = 1'b1;
                  n.rw   = q.sh[0];
                  n.sdrv = 1'b1;
                end else if (q.lost) begin
                  n.ph   = PH_HOLD;
                  n.stat = CODE_ARB;
                  n.flag = 1'b1;
                end else begin
                  n.ph = PH_IDLE;
                end
              end else begin
                n.sdrv = !q.rw && q.ack;
              end
            end else if (q.bitn == 4'h9) begin
              n.bitn = 4'h0;
              n.ph   = PH_HOLD;
              n.cdrv = 1'b1;
              n.flag = 1'b1;
              n.addr = 1'b0;
              if (q.addr) begin
                n.stat = q.rw ? (q.lost ? CODE_SRDL : CODE_SRD)
                              : (q.lost ? CODE_SWL : CODE_SW);
              end else if (q.rw) begin
                n.stat = q.nack ? CODE_STN : CODE_STA;
              end else begin
                n.stat = q.sdrv ? CODE_SDA : CODE_SDN;
              end
            end else if (q.rw && !q.addr) begin
              n.sdrv = !q.sh[7];
            end
          end
        end
        default: begin
          n.ph = PH_IDLE;
        end
      endcase
    end
    n.irq = n.flag && n.ie;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q      <= '0;
      q.div  <= RST_DIV;
      q.own  <= RST_OWN;
      q.sh   <= RST_DATA;
      q.stat <= CODE_NONE;
      q.scs  <= 3'h7;
      q.sds  <= 3'h7;
      q.scl  <= 1'b1;
      q.sda  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o = q.rd;
  assign scl_o       = q.zero;
  assign scl_oe_o    = q.cdrv;
  assign sda_o       = q.zero;
  assign sda_oe_o    = q.sdrv;
  assign irq_o       = q.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_STAT_IDLE: assert property (
    hit(reg_addr_i, OFS_STAT) && !q.flag |=> reg_rdata_o[7:3] == CODE_NONE[7:3])
    else $error("status not idle code");
  AST_BERR: assert property (
    q.en && bus_err |=> q.flag && q.stat == CODE_BERR && q.ph == PH_HOLD)
    else $error("bus error not reported");
  AST_RECOVER: assert property (
    q.en && q.ph == PH_HOLD && !q.flag && q.sto && !q.mst && !reg_wr_i
    |=> q.ph == PH_IDLE && !q.sto)
    else $error("recovery did not reach idle");
  AST_RELEASE: assert property (
    q.en && q.ph == PH_HOLD && !q.flag && q.sto && !q.mst
    |=> !scl_oe_o && !sda_oe_o ##1 !scl_oe_o)
    else $error("lines not released");
  AST_ARB_LOST: assert property (
    q.en && !bus_err && q.ph == PH_HIGH && q.scl && q.cnt == 16'h0000 && lose
    |=> !q.mst && !sda_oe_o)
    else $error("arbitration loss missed");
  AST_NO_CONT: assert property (
    q.en && !bus_err && q.ph == PH_HIGH && q.scl && q.cnt == 16'h0000 && !lose
    |=> q.mst)
    else $error("false contention");
  AST_RATE: assert property (
    q.en && !bus_err && q.ph == PH_LOW && q.cnt == 16'h0000
    |=> q.ph == PH_HIGH && q.cnt == 16'(BASE_HALF) + 16'($past(q.div)) *
        (($past(q.ps) == 2'h0) ? 16'h0001 : ($past(q.ps) == 2'h1) ? 16'h0004 :
         ($past(q.ps) == 2'h2) ? 16'h0010 : 16'h0040))
    else $error("bit rate count wrong");
  AST_WCOL: assert property (
    reg_wr_i && hit(reg_addr_i, OFS_DATA) && !q.flag |=> q.wcol)
    else $error("collision flag not set");
  AST_HOLD_SCL: assert property (
    q.en && q.ph == PH_HOLD && q.mst && q.flag |=> scl_oe_o)
    else $error("clock not held low");
  AST_RS_MASTER: assert property (
    q.en && q.ph == PH_RS |=> q.mst)
    else $error("master lost after repeated start");

  COV_START: cover property (q.ph == PH_START ##1 q.ph == PH_HOLD);
  COV_ARB: cover property (q.ph == PH_HIGH ##1 q.lost && !q.mst);
  COV_BERR: cover property (q.en && bus_err);
  COV_SLV: cover property (q.ph == PH_SLV ##1 q.slv);
endmodule // isac_ctrl

`default_nettype wire

// file: tb/isac_bus_peer.sv
// Far side of the two-wire bus: an addressed slave plus a second master.
// Assumes the bench resolves the open-drain wires and feeds them back in.
`timescale 1ns/1ps
`default_nettype none
module isac_bus_peer (
  input  wire logic       ref_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [6:0] addr_i,
  input  wire logic       slow_i,
  output logic            scl_oe_o,
  output logic            sda_oe_o
);
  import isac_pkg::*;
  localparam logic [7:0] RD_BYTE = 8'hC3;
  logic [3:0] bitn  = 4'h0;
  logic [7:0] byten = 8'h00;
  logic [7:0] sh    = 8'h00;
  logic       act   = 1'b0;
  logic       hit   = 1'b0;
  logic       rd    = 1'b0;
  logic       m_scl = 1'b0;
  logic       m_sda = 1'b0;
  logic       s_scl = 1'b0;
  logic       s_sda = 1'b0;
  assign scl_oe_o = m_scl | s_scl;
  assign sda_oe_o = m_sda | s_sda;
  // ********************
  // Slave side
  // ********************
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b1;
    bitn = 4'h0;
    byten = 8'h00;
    hit = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (bitn == 4'h8) begin
      bitn = 4'h0;
      byten++;
    end else begin
      sh = {sh[6:0], sda_i};
      bitn++;
    end
  end
  // Data moves well after SCL falls, never near the high phase
  always @(negedge scl_i) begin
    if (act) repeat (4) @(posedge ref_clk_i);
    s_sda = 1'b0;
    if (act && bitn == 4'h8) begin
      if (byten == 8'h00) begin
        hit = (sh[7:1] == addr_i);
        rd = sh[0];
      end
      s_sda = hit & ((byten == 8'h00) | ~rd);
    end else if (act && hit && rd && byten != 8'h00) begin
      s_sda = ~RD_BYTE[7 - bitn];
    end
    if (act && slow_i) begin
      s_scl = 1'b1;
      repeat (30) @(posedge ref_clk_i);
      s_scl = 1'b0;
    end
  end
  // ********************
  // Second master
  // ********************
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic idle();
    m_scl = 1'b0;
    m_sda = 1'b0;
  endtask
  task automatic ext_start();
    m_sda = 1'b1;
    hold(20);
    m_scl = 1'b1;
  endtask
  // Low phase counted from its own pull, high phase cut by any other pull
  task automatic ext_bit(input logic b);
    int k;
    m_sda = ~b;
    hold(20);
    m_scl = 1'b0;
    for (k = 0; k < 2000 && scl_i !== 1'b1; k++) hold(1);
    for (k = 0; k < 20 && scl_i === 1'b1; k++) hold(1);
    m_scl = 1'b1;
  endtask
  task automatic ext_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) ext_bit(b[i]);
    ext_bit(1'b1);
  endtask
  task automatic ext_stop();
    m_sda = 1'b1;
    hold(20);
    m_scl = 1'b0;
    hold(20);
    m_sda = 1'b0;
  endtask
endmodule // isac_bus_peer
`default_nettype wire

// file: tb/isac_ctrl_tb.sv
// Bench of the two-wire serial controller: registers, master, errors, arbitration.
// Assumes isac_pkg, isac_ctrl and isac_bus_peer are compiled first.
`timescale 1ns/1ps
`default_nettype none
module isac_ctrl_tb;
  import isac_pkg::*;
  localparam int DLY = 1;
  logic       ref_clk_i   = 1'b0;
  logic       sys_rst_i   = 1'b1;
  logic [7:0] reg_addr_i  = 8'h00;
  logic       reg_wr_i    = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic       scl_oe_o;
  logic       sda_oe_o;
  logic       irq_o;
  logic       scl_lo;
  logic       sda_lo;
  int         cyc         = 0;
  logic       p_scl;
  logic       p_sda;
  logic       slow        = 1'b0;
  logic       seen;
  wire logic  scl_w       = ~(scl_oe_o | p_scl);
  wire logic  sda_w       = ~(sda_oe_o | p_sda);
  int         miscompares = 0;
  int         tests_run   = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  isac_ctrl DUT (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .reg_addr_i (reg_addr_i),
    .reg_wr_i   (reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .scl_i      (scl_w),
    .scl_o      (scl_lo),
    .scl_oe_o   (scl_oe_o),
    .sda_i      (sda_w),
    .sda_o      (sda_lo),
    .sda_oe_o   (sda_oe_o),
    .irq_o      (irq_o)
  );
  isac_bus_peer peer (
    .ref_clk_i(ref_clk_i),
    .scl_i    (scl_w),
    .sda_i    (sda_w),
    .addr_i   (7'h50),
    .slow_i   (slow),
    .scl_oe_o (p_scl),
    .sda_oe_o (p_sda)
  );
  // ********************
  // Access tasks
  // ********************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge ref_clk_i) #DLY;
    reg_wr_i = 1'b0;
    @(posedge ref_clk_i) #DLY;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i = a;
    @(posedge ref_clk_i) #DLY;
    chk($sformatf("register %h", a), e, reg_rdata_o);
  endtask
  task automatic wait_ctl(input int b, input logic v);
    reg_addr_i = OFS_CTL;
    for (int k = 0; k < 20000; k++) begin
      @(posedge ref_clk_i) #DLY;
      if (reg_rdata_o[b] === v) break;
    end
    chk1("control wait", 1'b1, reg_rdata_o[b] === v);
  endtask
  task automatic do_reset();
    sys_rst_i = 1'b1;
    peer.idle();
    repeat (12) @(posedge ref_clk_i);
    #DLY sys_rst_i = 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    miscompares++;
    test_done();
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    #DLY do_reset();
    rd(OFS_DIV, RST_DIV);
    rd(OFS_CTL + OFS_DSPACE, 8'h00);
    rd(OFS_STAT, CODE_NONE);
    chk1("open-drain levels", 1'b0, scl_lo | sda_lo);
    rd(8'h10, 8'h00);
    wr(OFS_DIV + OFS_DSPACE, 8'hA5);
    rd(OFS_DIV, 8'hA5);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_STAT + OFS_DSPACE, 8'(p));
      rd(OFS_STAT, CODE_NONE | 8'(p));
    end
    wr(OFS_DATA, 8'h55);
    rd(OFS_CTL, 8'h08);
    wr(OFS_CTL, 8'h00);
    rd(OFS_CTL, 8'h08);
    rd(OFS_DATA, RST_DATA);
    // Write then read across a repeated start, slave stretching
    do_reset();
    slow = 1'b1;
    wr(OFS_DIV, 8'h01);
    wr(OFS_STAT, 8'h01);
    wr(OFS_CTL, 8'h24);
    cyc = 0;
    while (scl_oe_o !== 1'b1 && cyc < 300) begin
      @(posedge ref_clk_i) #DLY;
      cyc++;
    end
    chk("start hold cycles", 8'(BASE_HALF + 1 * 4 + 1), 8'(cyc));
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_STRT | 8'h01);
    chk1("scl hold", 1'b1, scl_oe_o);
    wr(OFS_DATA, 8'hA0);
    wr(OFS_CTL, 8'h84);
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_AWA | 8'h01);
    wr(OFS_CTL, 8'hA4);
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_RSTRT | 8'h01);
    chk1("scl kept", 1'b1, scl_oe_o);
    wr(OFS_DATA, 8'hA1);
    wr(OFS_CTL, 8'h84);
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_ARA | 8'h01);
    wr(OFS_CTL, 8'h84);
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_DRN | 8'h01);
    rd(OFS_DATA, 8'hC3);
    wr(OFS_CTL, 8'h94);
    wait_ctl(CB_STO, 1'b0);
    rd(OFS_CTL, 8'h04);
    // Let the stretched STOP finish so the next scenario starts on a free bus
    repeat (100) @(posedge ref_clk_i);
    #DLY chk1("bus free after stop", 1'b1, scl_w & sda_w & !peer.act);
    slow = 1'b0;
    // Stop in mid address byte
    do_reset();
    wr(OFS_CTL, 8'h45);
    peer.ext_start();
    repeat (3) peer.ext_bit(1'b0);
    peer.ext_stop();
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_BERR);
    chk1("irq", 1'b1, irq_o);
    wr(OFS_CTL, 8'hD5);
    rd(OFS_CTL, 8'h45);
    rd(OFS_STAT, CODE_NONE);
    seen = 1'b0;
    repeat (100) begin
      @(posedge ref_clk_i) #DLY;
      seen = seen | scl_oe_o | sda_oe_o;
    end
    chk1("lines after recovery", 1'b0, seen);
    // Lost in direction bit, own address acknowledged
    do_reset();
    wr(OFS_CTL, 8'h64);
    wait_ctl(CB_FLAG, 1'b1);
    peer.ext_start();
    wr(OFS_DATA, 8'h7F);
    wr(OFS_CTL, 8'hC4);
    peer.ext_byte(8'h7E);
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_SWL);
    chk1("slave hold", 1'b1, scl_oe_o);
    // Lost without ack, then restart once the bus is free
    do_reset();
    wr(OFS_CTL, 8'h24);
    wait_ctl(CB_FLAG, 1'b1);
    peer.ext_start();
    wr(OFS_DATA, 8'h7F);
    wr(OFS_CTL, 8'h84);
    peer.ext_byte(8'h7E);
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_ARB);
    chk1("lines after loss", 1'b0, scl_oe_o | sda_oe_o);
    wr(OFS_CTL, 8'hA4);
    peer.ext_stop();
    wait_ctl(CB_FLAG, 1'b1);
    rd(OFS_STAT, CODE_STRT);
    test_done();
  end
endmodule // isac_ctrl_tb
`default_nettype wire
